// ==== uart_pkg.sv ====
// constants, field positions and types shared by the serial transceiver control block
package uart_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_FORMAT = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_DIVISOR = 8'h10;
  localparam logic [7:0] OFF_AUX = 8'h14;

  // uart_format_control fields
  localparam int FMT_MASTER = 7;
  localparam int FMT_NINE = 6;
  localparam int FMT_PARITY = 5;
  localparam int FMT_ODD = 4;
  localparam int FMT_TWO_STOP = 3;
  localparam int FMT_BREAK = 2;
  localparam int FMT_RX9 = 1;
  localparam int FMT_TX9 = 0;

  // uart_enable_interrupt_control fields
  localparam int CTL_TX_ON = 7;
  localparam int CTL_RX_ON = 6;
  localparam int CTL_FAST = 5;
  localparam int CTL_ADDR = 4;
  localparam int CTL_WAKE = 3;
  localparam int CTL_RIE = 2;
  localparam int CTL_TX_IDLE_IRQ_EN = 1;
  localparam int CTL_TX_EMPTY_IRQ_EN = 0;

  // uart_status_flags fields
  localparam int STS_PARITY_ERROR_FLAG = 7;
  localparam int STS_NOISE = 6;
  localparam int STS_FRAME = 5;
  localparam int STS_OVR = 4;
  localparam int STS_RX_IDLE = 3;
  localparam int STS_RX_AVAIL = 2;
  localparam int STS_TX_IDLE = 1;
  localparam int STS_TX_EMPTY = 0;

  // aux register fields
  localparam int AUX_WAKE = 0;
  localparam int AUX_IRQ = 1;

  // values after reset
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h0b;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;

  // oversampling ticks per bit and frame counts
  localparam logic [6:0] SLOW_OVS = 7'h40;
  localparam logic [6:0] FAST_OVS = 7'h10;
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;
  localparam logic [3:0] BREAK_BITS = 4'hd;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b011,
    TX_PAR = 3'b010,
    TX_STOP = 3'b110,
    TX_BRK = 3'b100
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic tx_out;
    logic tx_oe;
    logic rx_en;
  } pins_t;

endpackage

// ==== uart_control_config.sv ====
// serial transceiver with control and configuration registers on an ahb-lite slave
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

module uart_control_config
  import uart_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_in,
  input wire logic uart_clk_off,
  output pins_t pins,
  output logic uart_irq,
  output logic wake_req
);

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] ctl;
    logic [7:0] div;
    logic [7:0] sts;
    logic [8:0] txbuf;
    logic txfull;
    logic tx_was;
    logic rx_was;
    logic seen;
    logic [7:0] pre;
    tx_state_t tx_st;
    logic [5:0] tx_ph;
    logic [8:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_par;
    logic [3:0] brk_cnt;
    rx_state_t rx_st;
    logic [5:0] rx_ph;
    logic [2:0] rx_samp;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_noise;
    logic [7:0] rxbuf;
    logic rx_prev;
    logic wake;
    logic irq;
    pins_t pins;
    logic wr_pend;
    logic [7:0] wr_off;
    logic [31:0] hrdata;
    logic ready;
  } state_t;

  state_t q;
  state_t n;

  logic addr_ok;
  logic tick;
  logic [5:0] ph_last;
  logic [5:0] ph_mid;
  logic [3:0] word_bits;
  logic [3:0] tx_data_bits;
  logic [3:0] tx_stop_bits;
  logic tx_run;
  logic rx_run;
  logic tx_end;
  logic rx_end;
  logic maj;
  logic noisy;
  logic [7:0] rd_val;
  logic [7:0] off;

  always_comb begin
    n = q;
    n.ready = 1'b1;
    n.wr_pend = 1'b0;
    off = {haddr[7:2], 2'b00};
    addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

    // tx ninth bit is write-only and reads back as zero
    unique case (off)
      OFF_STATUS: rd_val = q.sts;
      OFF_FORMAT: rd_val = {q.fmt[7:1], 1'b0};
      OFF_ENABLE: rd_val = q.ctl;
      OFF_DATA: rd_val = q.rxbuf;
      OFF_DIVISOR: rd_val = q.div;
      OFF_AUX: rd_val = {6'h00, q.irq, q.wake};
      default: rd_val = 8'h00;
    endcase

    // address phase: reads answer in the following data phase
    if (addr_ok && !hwrite) begin
      n.hrdata = {24'h000000, rd_val};
      if (off == OFF_STATUS) begin
        n.seen = 1'b1;
      end else if (off == OFF_DATA) begin
        // receive flags clear only after a status read
        if (q.seen) begin
          n.sts[STS_RX_AVAIL] = 1'b0;
          n.sts[STS_OVR] = 1'b0;
          n.sts[STS_FRAME] = 1'b0;
          n.sts[STS_PARITY_ERROR_FLAG] = 1'b0;
          n.sts[STS_NOISE] = 1'b0;
        end
        n.seen = 1'b0;
      end
    end
    if (addr_ok && hwrite) begin
      n.wr_pend = 1'b1;
      n.wr_off = off;
    end

    // data phase of a write
    if (q.wr_pend) begin
      unique case (q.wr_off)
        OFF_FORMAT: begin
          n.fmt = {hwdata[7:2], q.fmt[FMT_RX9], hwdata[FMT_TX9]};
        end
        OFF_ENABLE: n.ctl = hwdata[7:0];
        OFF_DIVISOR: n.div = hwdata[7:0];
        OFF_DATA: begin
          // ninth bit latched with the byte
          n.txbuf = {q.fmt[FMT_TX9], hwdata[7:0]};
          n.txfull = 1'b1;
          if (q.seen) begin
            n.sts[STS_TX_EMPTY] = 1'b0;
            n.sts[STS_TX_IDLE] = 1'b0;
            n.sts[STS_OVR] = 1'b0;
            n.sts[STS_FRAME] = 1'b0;
            n.sts[STS_PARITY_ERROR_FLAG] = 1'b0;
            n.sts[STS_NOISE] = 1'b0;
          end
          n.seen = 1'b0;
        end
        default: n.seen = q.seen;
      endcase
    end

    // transmitter runs only under both enables
    tx_run = n.fmt[FMT_MASTER] && n.ctl[CTL_TX_ON];
    // receiver runs only under both enables
    rx_run = n.fmt[FMT_MASTER] && n.ctl[CTL_RX_ON];

    // prescaler divides by divisor plus one, bit lasts 64 or 16 ticks
    tick = (q.pre >= q.div);
    n.pre = tick ? 8'h00 : q.pre + 8'h01;
    // speed select picks the tick count per bit
    ph_last = q.ctl[CTL_FAST] ? 6'(FAST_OVS - 7'h01) : 6'(SLOW_OVS - 7'h01);
    ph_mid = q.ctl[CTL_FAST] ? 6'(FAST_OVS >> 1) : 6'(SLOW_OVS >> 1);
    word_bits = q.fmt[FMT_NINE] ? WORD_BITS_9 : WORD_BITS_8;
    // parity bit takes the last word slot
    tx_data_bits = q.fmt[FMT_PARITY] ? word_bits - 4'h1 : word_bits;
    // one or two stop bits on transmit
    tx_stop_bits = q.fmt[FMT_TWO_STOP] ? 4'h2 : 4'h1;

    // transmitter
    tx_end = tick && (q.tx_ph == ph_last);
    if (q.tx_st != TX_IDLE && tick) begin
      n.tx_ph = tx_end ? 6'h00 : q.tx_ph + 6'h01;
    end
    unique case (q.tx_st)
      TX_IDLE: begin
        if (n.txfull) begin
          n.tx_sh = n.txbuf;
          n.txfull = 1'b0;
          n.sts[STS_TX_EMPTY] = 1'b1;
          n.tx_cnt = 4'h0;
          n.tx_par = 1'b0;
          n.tx_ph = 6'h00;
          n.tx_st = TX_START;
        // break only after buffered data is gone
        end else if (q.fmt[FMT_BREAK]) begin
          n.brk_cnt = 4'h0;
          n.tx_ph = 6'h00;
          n.tx_st = TX_BRK;
        end else begin
          n.sts[STS_TX_IDLE] = 1'b1;
        end
      end
      TX_START: begin
        if (tx_end) begin
          n.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_end) begin
          n.tx_par = q.tx_par ^ q.tx_sh[0];
          n.tx_sh = {1'b0, q.tx_sh[8:1]};
          n.tx_cnt = q.tx_cnt + 4'h1;
          if (q.tx_cnt + 4'h1 == tx_data_bits) begin
            n.tx_cnt = 4'h0;
            n.tx_st = q.fmt[FMT_PARITY] ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: begin
        if (tx_end) begin
          n.tx_st = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_end) begin
          n.tx_cnt = q.tx_cnt + 4'h1;
          if (q.tx_cnt + 4'h1 == tx_stop_bits) begin
            n.tx_st = TX_IDLE;
          end
        end
      end
      TX_BRK: begin
        // low for at least 13 bits and until break is cleared
        if (tx_end) begin
          if (q.brk_cnt != BREAK_BITS) begin
            n.brk_cnt = q.brk_cnt + 4'h1;
          end
          if (q.brk_cnt >= BREAK_BITS - 4'h1 && !q.fmt[FMT_BREAK]) begin
            n.tx_st = TX_IDLE;
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    // dropping the transmitter aborts and flushes
    if (!tx_run) begin
      n.tx_st = TX_IDLE;
      n.tx_ph = 6'h00;
      if (q.tx_was) begin
        n.txfull = 1'b0;
      end
    end
    n.tx_was = tx_run;

    // receiver, three samples around mid-bit for noise
    rx_end = tick && (q.rx_ph == ph_last);
    maj = (q.rx_samp[0] & q.rx_samp[1]) | (q.rx_samp[1] & q.rx_samp[2])
        | (q.rx_samp[0] & q.rx_samp[2]);
    noisy = (q.rx_samp != 3'b000) && (q.rx_samp != 3'b111);
    if (q.rx_st != RX_IDLE && tick) begin
      n.rx_ph = rx_end ? 6'h00 : q.rx_ph + 6'h01;
      if (q.rx_ph == ph_mid - 6'h01 || q.rx_ph == ph_mid || q.rx_ph == ph_mid + 6'h01) begin
        n.rx_samp = {q.rx_samp[1:0], rx_in};
      end
    end
    unique case (q.rx_st)
      RX_IDLE: begin
        n.sts[STS_RX_IDLE] = 1'b1;
        if (!rx_in && q.rx_prev) begin
          n.rx_st = RX_START;
          n.rx_ph = 6'h00;
          n.rx_sh = 9'h000;
          n.rx_noise = 1'b0;
          n.sts[STS_RX_IDLE] = 1'b0;
        end
      end
      RX_START: begin
        if (rx_end) begin
          n.rx_noise = noisy;
          n.rx_cnt = 4'h0;
          // a high start sample is a glitch, not a frame
          n.rx_st = maj ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_end) begin
          n.rx_noise = q.rx_noise | noisy;
          n.rx_sh = {maj, q.rx_sh[8:1]};
          n.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt + 4'h1 == word_bits) begin
            n.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_end) begin
          n.rx_st = RX_IDLE;
          // address bit lands at the top of the word in both sizes
          // data words are dropped while address detect is on
          if (!(q.ctl[CTL_ADDR] && !q.rx_sh[8])) begin
            if (q.sts[STS_RX_AVAIL]) begin
              n.sts[STS_OVR] = 1'b1;
            end else begin
              n.rxbuf = q.fmt[FMT_NINE] ? q.rx_sh[7:0] : q.rx_sh[8:1];
              // ninth received bit kept in the format register
              n.fmt[FMT_RX9] = q.fmt[FMT_NINE] & q.rx_sh[8];
              n.sts[STS_RX_AVAIL] = 1'b1;
              n.sts[STS_FRAME] = ~maj;
              n.sts[STS_NOISE] = q.rx_noise | noisy;
              n.sts[STS_PARITY_ERROR_FLAG] = q.fmt[FMT_PARITY] & ((^q.rx_sh) ^ q.fmt[FMT_ODD]);
            end
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase
    // dropping the receiver aborts and flushes
    if (!rx_run) begin
      n.rx_st = RX_IDLE;
      n.rx_ph = 6'h00;
      n.sts[STS_RX_IDLE] = 1'b1;
      if (q.rx_was) begin
        n.sts[STS_RX_AVAIL] = 1'b0;
      end
    end
    n.rx_was = rx_run;

    // wake only while the uart clock is off; held until it returns
    n.rx_prev = rx_in;
    if (!uart_clk_off) begin
      n.wake = 1'b0;
    end
    if (q.ctl[CTL_WAKE] && uart_clk_off && q.rx_prev && !rx_in) begin
      n.wake = 1'b1;
    end

    // disable flushes buffer and baud counter
    // any transfer in flight is cut off at once
    if (!n.fmt[FMT_MASTER]) begin
      // disable state of enables and flags
      n.ctl[CTL_TX_ON] = 1'b0;
      n.ctl[CTL_RX_ON] = 1'b0;
      n.fmt[FMT_BREAK] = 1'b0;
      n.sts[STS_RX_AVAIL] = 1'b0;
      n.sts[STS_OVR] = 1'b0;
      n.sts[STS_FRAME] = 1'b0;
      n.sts[STS_PARITY_ERROR_FLAG] = 1'b0;
      n.sts[STS_NOISE] = 1'b0;
      n.sts[STS_TX_IDLE] = 1'b1;
      n.sts[STS_TX_EMPTY] = 1'b1;
      n.sts[STS_RX_IDLE] = 1'b1;
      n.txfull = 1'b0;
      n.pre = 8'h00;
      n.tx_st = TX_IDLE;
      n.rx_st = RX_IDLE;
      n.tx_ph = 6'h00;
      n.rx_ph = 6'h00;
    end

    n.irq = (n.ctl[CTL_RIE] & (n.sts[STS_RX_AVAIL] | n.sts[STS_OVR]))
          | (n.ctl[CTL_TX_IDLE_IRQ_EN] & n.sts[STS_TX_IDLE])
          | (n.ctl[CTL_TX_EMPTY_IRQ_EN] & n.sts[STS_TX_EMPTY])
          | n.wake;

    // pins float unless master and their own enable are set
    n.pins.tx_oe = tx_run;
    n.pins.rx_en = rx_run;
    unique case (n.tx_st)
      TX_START: n.pins.tx_out = 1'b0;
      TX_BRK: n.pins.tx_out = 1'b0;
      TX_DATA: n.pins.tx_out = n.tx_sh[0];
      // odd adds one to the running parity
      TX_PAR: n.pins.tx_out = n.tx_par ^ n.fmt[FMT_ODD];
      default: n.pins.tx_out = 1'b1;
    endcase
  end

  // disable touches no other control bit; divisor kept
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
      q.fmt <= FORMAT_RESET;
      q.ctl <= ENABLE_RESET;
      q.sts <= STATUS_RESET;
      q.div <= DIVISOR_RESET;
      q.ready <= 1'b1;
      q.rx_prev <= 1'b1;
      q.pins.tx_out <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.ready;
  // only whole-word transfers are expected, so size is not checked
  assign hresp = q.wr_pend & 1'b0 & hsize[0];
  assign pins = q.pins;
  assign uart_irq = q.irq;
  assign wake_req = q.wake;

endmodule

// ==== uart_control_config_properties.sv ====
// port-level checker for the serial transceiver control block
`timescale 1ns/1ps
module uart_control_config_check
  import uart_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic uart_clk_off,
  input wire pins_t pins,
  input wire logic uart_irq,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !pins.tx_oe && !pins.rx_en && pins.tx_out && !uart_irq && !wake_req)
    else $error("outputs not parked after reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_tx_float_high: assert property (!pins.tx_oe |-> pins.tx_out)
    else $error("tx level low while not driven");
  a_read_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_data_narrow: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data bits set");
  a_wake_cause: assert property ($rose(wake_req) |-> $past(uart_clk_off))
    else $error("wake request while uart clock runs");
  a_wake_drop: assert property ($fell(uart_clk_off) |=> !wake_req)
    else $error("wake request kept after clock restart");
  a_wake_irq: assert property (wake_req |-> ##[0:2] uart_irq)
    else $error("wake request not merged into interrupt");

  c_tx_on: cover property ($rose(pins.tx_oe));
  c_wake: cover property ($rose(wake_req));
  c_irq: cover property ($rose(uart_irq));
endmodule

bind uart_control_config uart_control_config_check chk_u (.core_clk, .rst, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .uart_clk_off, .pins, .uart_irq, .wake_req);

// ==== serial_peer.sv ====
// far-end serial device: sends frames on rx and samples frames from tx
`timescale 1ns/1ps
module serial_peer (
  input wire logic core_clk,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic [15:0] bit_clks,
  output logic rx_line,
  output logic [10:0] cap,
  output logic got
);
  initial begin
    rx_line = 1'b1;
    got = 1'b0;
    cap = '0;
  end

  // slots sampled mid-bit at the programmed rate
  always begin
    @(posedge core_clk);
    if (tx_oe === 1'b1 && tx_out === 1'b0) begin
      repeat (bit_clks / 2) @(posedge core_clk);
      for (int i = 0; i < 11; i++) begin
        repeat (bit_clks) @(posedge core_clk);
        cap[i] <= tx_out;
      end
      got <= 1'b1;
      @(posedge core_clk);
      got <= 1'b0;
    end
  end

  // line driven high again after the stop slot, lsb first
  task automatic send(input logic [9:0] slots);
    for (int i = 0; i < 10; i++) begin
      rx_line <= slots[i];
      repeat (bit_clks) @(posedge core_clk);
    end
    rx_line <= 1'b1;
  endtask
endmodule

// ==== uart_control_config_test.sv ====
// self-checking bench for the serial transceiver control block
`timescale 1ns/1ps
module uart_control_config_test
  import uart_pkg::*;
;
  typedef struct packed {
    logic [7:0] fmt, ctl, div, dat;
    logic [10:0] cap;
  } frame_t;
  logic core_clk, rst, hsel, hwrite, hreadyout, hresp, rx_in, uart_clk_off, uart_irq;
  logic wake_req, got;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] bit_clks;
  logic [10:0] cap;
  pins_t pins;
  wire hready = hreadyout;
  int n_errors, check_count, cycles, n, i;
  // address, write data, read-back, interrupt
  localparam logic [24:0] ROWS [8] = '{
    {OFF_ENABLE, 8'hc0, 8'h00, 1'b0}, {OFF_FORMAT, 8'hf9, 8'hf8, 1'b0},
    {OFF_ENABLE, 8'hc0, 8'hc0, 1'b0}, {OFF_ENABLE, 8'hc1, 8'hc1, 1'b1},
    {OFF_ENABLE, 8'hc2, 8'hc2, 1'b1}, {OFF_ENABLE, 8'hc4, 8'hc4, 1'b0},
    {OFF_DIVISOR, 8'h5a, 8'h5a, 1'b0}, {8'h18, 8'haa, 8'h00, 1'b0}};
  localparam frame_t FRAMES [5] = '{
    '{8'h80, 8'ha0, 8'h00, 8'ha5, 11'h7a5}, '{8'hf1, 8'ha0, 8'h00, 8'h07, 11'h607},
    '{8'hc1, 8'ha0, 8'h00, 8'h00, 11'h700}, '{8'ha0, 8'ha0, 8'h00, 8'h81, 11'h781},
    '{8'h80, 8'h80, 8'h01, 8'h5c, 11'h75c}};

  uart_control_config dut_u (.core_clk(core_clk), .rst(rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in),
    .uart_clk_off(uart_clk_off), .pins(pins), .uart_irq(uart_irq), .wake_req(wake_req));
  serial_peer peer_u (.core_clk(core_clk), .tx_out(pins.tx_out), .tx_oe(pins.tx_oe),
    .bit_clks(bit_clks), .rx_line(rx_in), .cap(cap), .got(got));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 8'h00, x);
    check(x & {24'h0, m}, {24'h0, e});
  endtask

  task automatic rx_frame(input logic [7:0] d);
    peer_u.send({1'b1, d, 1'b0});
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    rst <= 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} <= '0;
    uart_clk_off <= 1'b0;
    bit_clks <= 16'd16;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc(OFF_STATUS, 8'hff, STATUS_RESET);
    rdc(OFF_FORMAT, 8'hff, 8'h00);
    rdc(OFF_ENABLE, 8'hff, 8'h00);
    check({27'h0, pins, uart_irq, wake_req}, 32'h10);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      wr(ROWS[i][24:17], ROWS[i][16:9]);
      rdc(ROWS[i][24:17], 8'hff, ROWS[i][8:1]);
      check({31'h0, uart_irq}, {31'h0, ROWS[i][0]});
    end
    check({29'h0, pins}, 32'h7);
    $display("test register rows done");
    for (i = 0; i < 5; i++) begin
      wr(OFF_FORMAT, FRAMES[i].fmt);
      wr(OFF_ENABLE, FRAMES[i].ctl);
      wr(OFF_DIVISOR, FRAMES[i].div);
      bit_clks <= (16'(FRAMES[i].div) + 16'd1) * (FRAMES[i].ctl[CTL_FAST] ? 16'd16 : 16'd64);
      wr(OFF_DATA, FRAMES[i].dat);
      while (got !== 1'b1) @(posedge core_clk);
      check({21'h0, cap}, {21'h0, FRAMES[i].cap});
    end
    $display("test tx frames done");
    wr(OFF_DIVISOR, 8'h00);
    bit_clks <= 16'd16;
    wr(OFF_ENABLE, 8'h64);
    rx_frame(8'h3c);
    check({31'h0, uart_irq}, 32'h1);
    rdc(OFF_STATUS, 8'h04, 8'h04);
    rdc(OFF_DATA, 8'hff, 8'h3c);
    rdc(OFF_STATUS, 8'h04, 8'h00);
    wr(OFF_ENABLE, 8'h74);
    rx_frame(8'h12);
    rdc(OFF_STATUS, 8'h04, 8'h00);
    check({31'h0, uart_irq}, 32'h0);
    rx_frame(8'h92);
    check({31'h0, uart_irq}, 32'h1);
    rdc(OFF_STATUS, 8'h04, 8'h04);
    rdc(OFF_DATA, 8'hff, 8'h92);
    rx_frame(8'h93);
    wr(OFF_ENABLE, 8'h00);
    rdc(OFF_STATUS, 8'h04, 8'h00);
    check({31'h0, pins.rx_en}, 32'h0);
    wr(OFF_FORMAT, 8'hc0);
    wr(OFF_ENABLE, 8'h60);
    // ninth bit rides in the tenth slot; the idle line after it is the stop
    rx_frame(8'h5a);
    repeat (16) @(posedge core_clk);
    rdc(OFF_FORMAT, 8'h02, 8'h02);
    rdc(OFF_DATA, 8'hff, 8'h5a);
    wr(OFF_FORMAT, 8'h80);
    $display("test rx done");
    wr(OFF_ENABLE, 8'ha0);
    wr(OFF_FORMAT, 8'h84);
    while (pins.tx_out !== 1'b0) @(posedge core_clk);
    repeat (100) @(posedge core_clk);
    wr(OFF_FORMAT, 8'h80);
    n = 102;
    while (pins.tx_out === 1'b0) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, n >= 13 * 16}, 32'h1);
    $display("test break done");
    wr(OFF_ENABLE, 8'ha7);
    wr(OFF_DIVISOR, 8'h33);
    wr(OFF_DATA, 8'h00);
    // second byte waits in the buffer; disable must drop it
    wr(OFF_DATA, 8'h00);
    repeat (40) @(posedge core_clk);
    wr(OFF_FORMAT, 8'h00);
    // pins launched at the write edge are seen one edge later
    @(posedge core_clk);
    check({29'h0, pins}, 32'h4);
    rdc(OFF_STATUS, 8'hff, 8'h0b);
    rdc(OFF_ENABLE, 8'hff, 8'h27);
    rdc(OFF_DIVISOR, 8'hff, 8'h33);
    wr(OFF_FORMAT, 8'h80);
    wr(OFF_ENABLE, 8'ha0);
    repeat (20) @(posedge core_clk);
    check({29'h0, pins}, 32'h6);
    $display("test disable done");
    wr(OFF_ENABLE, 8'h08);
    rx_frame(8'h00);
    check({31'h0, wake_req}, 32'h0);
    uart_clk_off <= 1'b1;
    rx_frame(8'h00);
    check({30'h0, wake_req, uart_irq}, 32'h3);
    rdc(OFF_AUX, 8'h03, 8'h03);
    uart_clk_off <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({31'h0, wake_req}, 32'h0);
    $display("test wake done");
    give_verdict();
  end
endmodule
